//--- core/rasq_regs.vh
`ifndef RASQ_REGS_VH
`define RASQ_REGS_VH

// register byte offsets (haddr[7:0])
`define RASQ_CMD_OFS 8'h00
`define RASQ_SPEC_OFS 8'h04
`define RASQ_LATCH_OFS 8'h08
`define RASQ_WORK_OFS 8'h0c
`define RASQ_FLAGS_OFS 8'h10
`define RASQ_IRQ_STAT_OFS 8'h14
`define RASQ_IRQ_MASK_OFS 8'h18

// command register fields
`define RASQ_CMD_CODE_HI 1
`define RASQ_CMD_CODE_LO 0
`define RASQ_CMD_CHAN_HI 5
`define RASQ_CMD_CHAN_LO 4
`define RASQ_CMD_MEASURE 2'h1
`define RASQ_CMD_CALIBRATE 2'h2
`define RASQ_CMD_CHECK 2'h3

// conversion-specification operand fields
`define RASQ_SPEC_COUNT_HI 3
`define RASQ_SPEC_COUNT_LO 0
`define RASQ_SPEC_COMP_BIT 7

// latch register and flags register fields
`define RASQ_LATCH_CSRC_BIT 0
`define RASQ_FLAG_ZERO_BIT 0
`define RASQ_FLAG_NEG_BIT 1
`define RASQ_FLAG_POS_BIT 2
`define RASQ_FLAG_BUSY_BIT 3
`define RASQ_FLAG_ARMED_BIT 4

// interrupt status / mask fields
`define RASQ_IRQ_DONE_BIT 0
`define RASQ_IRQ_RANGE_BIT 1
`define RASQ_IRQ_WIDTH 2

// reset values
`define RASQ_WORK_RESET 32'h0000_0000
`define RASQ_MASK_RESET 2'h0

// out-of-range codes
`define RASQ_CODE_UNDER 12'h000
`define RASQ_CODE_OVER 12'hfff

// timing
`define RASQ_CLK_MHZ 20
`define RASQ_PWR_SETTLE_NS 5000
`define RASQ_BIT_SETTLE_NS 400
`define RASQ_PWR_CYCLES ((`RASQ_PWR_SETTLE_NS * `RASQ_CLK_MHZ + 999) / 1000)
`define RASQ_BIT_CYCLES ((`RASQ_BIT_SETTLE_NS * `RASQ_CLK_MHZ + 999) / 1000)

`endif

//--- core/rasq_sync.v
`timescale 1ns/1ns
`default_nettype none

module rasq_sync
(
   input wire clock, // system clock
   input wire rstn, // async reset, active low
   input wire din, // asynchronous level
   output reg dout // synchronised level
);

reg stage1;

always @(posedge clock or negedge rstn)
begin
   if (!rstn)
   begin
      stage1 <= 1'b0;
      dout <= 1'b0;
   end
   else
   begin
      stage1 <= din;
      dout <= stage1;
   end
end

endmodule // rasq_sync

`default_nettype wire

//--- core/rasq_sar.v
`timescale 1ns/1ns
`default_nettype none

module rasq_sar
#(
   // below 3 the bit decision reads a stale comparator through the sync
   parameter SETTLE = 8
)
(
   input wire clock, // system clock
   input wire rstn, // async reset, active low
   input wire start, // one-cycle start pulse
   input wire invert, // comparator inputs swapped
   input wire cmp, // synchronised comparator: input above dac
   output reg [11:0] dac_code, // trial code to the dac
   output reg [11:0] result, // finished conversion
   output reg done // one-cycle pulse, result valid
);

reg busy;
reg [11:0] bit_mask;
reg [7:0] cnt;
wire keep = cmp ^ invert; // swapped inputs flip the comparator sense
wire [11:0] trial = keep ? dac_code : (dac_code & ~bit_mask);

always @(posedge clock or negedge rstn)
begin
   if (!rstn)
   begin
      busy <= 1'b0;
      bit_mask <= 12'h000;
      cnt <= 8'h00;
      dac_code <= 12'h000;
      result <= 12'h000;
      done <= 1'b0;
   end
   else
   begin
      done <= 1'b0;
      if (start)
      begin
         busy <= 1'b1;
         bit_mask <= 12'h800;
         dac_code <= 12'h800;
         cnt <= 8'h00;
      end
      else if (busy)
      begin
         if (cnt == SETTLE[7:0] - 8'h01)
         begin
            cnt <= 8'h00;
            if (bit_mask[0])
            begin
               result <= trial;
               done <= 1'b1;
               busy <= 1'b0;
               dac_code <= 12'h000;
            end
            else
            begin
               dac_code <= trial | {1'b0, bit_mask[11:1]};
               bit_mask <= {1'b0, bit_mask[11:1]};
            end
         end
         else
            cnt <= cnt + 8'h01;
      end
   end
end

endmodule // rasq_sar

`default_nettype wire

//--- core/rasq_sequencer.v
`timescale 1ns/1ns
`default_nettype none
`include "rasq_regs.vh"

module rasq_sequencer
#(
   parameter PWR_CYCLES = `RASQ_PWR_CYCLES,
   parameter BIT_CYCLES = `RASQ_BIT_CYCLES
)
(
   input wire clock, // 20 MHz system clock
   input wire rstn, // async reset, active low
   input wire hsel, // ahb slave select
   input wire [31:0] haddr, // ahb address
   input wire [1:0] htrans, // ahb transfer type
   input wire hwrite, // ahb write
   input wire [2:0] hsize, // ahb size, word only
   input wire [31:0] hwdata, // ahb write data
   input wire hready, // ahb bus ready
   output reg [31:0] hrdata, // ahb read data
   output reg hreadyout, // ahb slave ready
   output reg hresp, // ahb response, always okay
   input wire cmp_pin, // analog comparator output, asynchronous
   output wire [11:0] dac_code, // sar trial code
   output reg comparator_swap, // comparator inputs reversed
   output reg switched_sensor_supply, // sensor supply enable
   output reg current_source_en, // sensor current source enable
   output reg reference_select_latch, // internal reference to adc
   output reg channel_select_lo, // input mux select, low
   output reg channel_select_hi, // input mux select, high
   output reg irq // level interrupt
);

localparam ST_IDLE = 3'd0;
localparam ST_POWER = 3'd1;
localparam ST_START = 3'd2;
localparam ST_WAIT = 3'd3;
localparam ST_FINISH = 3'd4;

// bus data phase
reg dph_valid;
reg dph_write;
reg [7:0] dph_addr;

// software-visible state
reg [31:0] main_working_register;
reg current_source_latch;
reg meas_armed;
reg [1:0] armed_chan;
reg zero_flag;
reg negative_flag;
reg positive_flag;
reg [`RASQ_IRQ_WIDTH-1:0] irq_status;
reg [`RASQ_IRQ_WIDTH-1:0] irq_mask;

// sequencer state
reg [2:0] state;
reg [11:0] pwr_cnt;
reg [4:0] conv_left;
reg comp_mode;
reg [1:0] op;
reg [16:0] acc;
reg under;
reg over;
reg sar_start;

wire cmp_sync;
wire [11:0] sar_result;
wire sar_done;

rasq_sync u_cmp_sync
(
   .clock(clock),
   .rstn(rstn),
   .din(cmp_pin),
   .dout(cmp_sync)
);

rasq_sar #(.SETTLE(BIT_CYCLES)) u_sar
(
   .clock(clock),
   .rstn(rstn),
   .start(sar_start),
   .invert(comparator_swap),
   .cmp(cmp_sync),
   .dac_code(dac_code),
   .result(sar_result),
   .done(sar_done)
);

wire addr_ok = hsel & hready & htrans[1];
wire wr = dph_valid & dph_write;
wire idle = (state == ST_IDLE);
wire [1:0] cmd_code = hwdata[`RASQ_CMD_CODE_HI:`RASQ_CMD_CODE_LO];
wire [3:0] spec_count = hwdata[`RASQ_SPEC_COUNT_HI:`RASQ_SPEC_COUNT_LO];

wire wr_cmd = wr & (dph_addr == `RASQ_CMD_OFS);
wire wr_spec = wr & (dph_addr == `RASQ_SPEC_OFS);
wire wr_latch = wr & (dph_addr == `RASQ_LATCH_OFS);
wire wr_work = wr & (dph_addr == `RASQ_WORK_OFS);
wire wr_istat = wr & (dph_addr == `RASQ_IRQ_STAT_OFS);
wire wr_imask = wr & (dph_addr == `RASQ_IRQ_MASK_OFS);

// battery commands start at once; measure waits for its operand
wire go_batt = wr_cmd & idle & (cmd_code == `RASQ_CMD_CALIBRATE
   | cmd_code == `RASQ_CMD_CHECK);
wire go_meas = wr_spec & idle & meas_armed;
wire go = go_batt | go_meas;

wire conv_end = (state == ST_WAIT) & sar_done;
wire pair_open = comp_mode & ~comparator_swap;
wire last_end = conv_end & ~pair_open & (conv_left == 5'd1);
wire [11:0] fresh = sar_result;
wire fresh_under = (fresh == `RASQ_CODE_UNDER);
wire fresh_over = (fresh == `RASQ_CODE_OVER);

// supply state one edge ahead, so the source never outlives it
wire next_supply = go ? 1'b1 : (last_end ? 1'b0 : switched_sensor_supply);
wire next_csrc_latch = wr_latch ? hwdata[`RASQ_LATCH_CSRC_BIT] : current_source_latch;

// saturated value of a finished sequence; overrange wins if both seen
wire [16:0] meas_val = over ? {5'h00, `RASQ_CODE_OVER} :
   (under ? {5'h00, `RASQ_CODE_UNDER} : acc);
wire [31:0] meas_word = {15'h0000, meas_val};
wire out_range = under | over;

// ahb slave: zero wait state, registered read data
always @(posedge clock or negedge rstn)
begin
   if (!rstn)
   begin
      dph_valid <= 1'b0;
      dph_write <= 1'b0;
      dph_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
   end
   else
   begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready)
      begin
         dph_valid <= addr_ok;
         dph_write <= hwrite;
         dph_addr <= haddr[7:0];
      end
      if (addr_ok & ~hwrite)
      begin
         case (haddr[7:0])
            `RASQ_CMD_OFS: hrdata <= {26'h0000000, armed_chan, 2'h0, op};
            `RASQ_SPEC_OFS: hrdata <= {24'h000000, comp_mode, 2'h0, conv_left};
            `RASQ_LATCH_OFS: hrdata <= {31'h00000000, current_source_latch};
            `RASQ_WORK_OFS: hrdata <= main_working_register;
            `RASQ_FLAGS_OFS: hrdata <= {27'h0000000, meas_armed, ~idle,
               positive_flag, negative_flag, zero_flag};
            `RASQ_IRQ_STAT_OFS: hrdata <= {30'h00000000, irq_status};
            `RASQ_IRQ_MASK_OFS: hrdata <= {30'h00000000, irq_mask};
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end
end

// software registers
always @(posedge clock or negedge rstn)
begin
   if (!rstn)
   begin
      current_source_latch <= 1'b0;
      meas_armed <= 1'b0;
      armed_chan <= 2'h0;
      irq_mask <= `RASQ_MASK_RESET;
      irq <= 1'b0;
   end
   else
   begin
      current_source_latch <= next_csrc_latch;
      if (wr_imask)
         irq_mask <= hwdata[`RASQ_IRQ_WIDTH-1:0];
      if (wr_cmd & idle & (cmd_code == `RASQ_CMD_MEASURE))
      begin
         meas_armed <= 1'b1;
         armed_chan <= hwdata[`RASQ_CMD_CHAN_HI:`RASQ_CMD_CHAN_LO];
      end
      else if (go)
         meas_armed <= 1'b0;
      irq <= |(irq_status & irq_mask);
   end
end

// sticky interrupt status, write one to clear, a new event wins
always @(posedge clock or negedge rstn)
begin
   if (!rstn)
      irq_status <= {`RASQ_IRQ_WIDTH{1'b0}};
   else
   begin
      if (wr_istat)
         irq_status <= irq_status & ~hwdata[`RASQ_IRQ_WIDTH-1:0]
            | ((state == ST_FINISH) ? {out_range & (op != `RASQ_CMD_CHECK), 1'b1}
            : 2'b00);
      else if (state == ST_FINISH)
      begin
         irq_status[`RASQ_IRQ_DONE_BIT] <= 1'b1;
         if (out_range & (op != `RASQ_CMD_CHECK))
            irq_status[`RASQ_IRQ_RANGE_BIT] <= 1'b1;
      end
   end
end

// supply, current source and analog selects
always @(posedge clock or negedge rstn)
begin
   if (!rstn)
   begin
      switched_sensor_supply <= 1'b0;
      current_source_en <= 1'b0;
      reference_select_latch <= 1'b0;
      channel_select_lo <= 1'b0;
      channel_select_hi <= 1'b0;
   end
   else
   begin
      switched_sensor_supply <= next_supply;
      current_source_en <= next_csrc_latch & next_supply;
      if (go_batt)
         reference_select_latch <= 1'b1;
      else if (go_meas)
      begin
         // command channel 0..3 -> lo/hi: 1/0, 0/0, 1/1, 0/1
         reference_select_latch <= 1'b0;
         channel_select_lo <= ~armed_chan[0];
         channel_select_hi <= armed_chan[1];
      end
   end
end

// conversion sequencer
always @(posedge clock or negedge rstn)
begin
   if (!rstn)
   begin
      state <= ST_IDLE;
      pwr_cnt <= 12'h000;
      conv_left <= 5'd0;
      comp_mode <= 1'b0;
      op <= 2'h0;
      acc <= 17'h00000;
      under <= 1'b0;
      over <= 1'b0;
      sar_start <= 1'b0;
      comparator_swap <= 1'b0;
   end
   else
   begin
      sar_start <= 1'b0;
      case (state)
         ST_IDLE:
         begin
            if (go)
            begin
               acc <= 17'h00000;
               under <= 1'b0;
               over <= 1'b0;
               pwr_cnt <= 12'h000;
               comparator_swap <= 1'b0;
               state <= ST_POWER;
               if (go_meas)
               begin
                  op <= `RASQ_CMD_MEASURE;
                  // count 0 stands for 16 conversions, or 16 swapped pairs when comp_mode is set
                  conv_left <= (spec_count == 4'h0) ? 5'd16 : {1'b0, spec_count};
                  comp_mode <= hwdata[`RASQ_SPEC_COMP_BIT];
               end
               else
               begin
                  op <= cmd_code;
                  conv_left <= 5'd1;
                  comp_mode <= 1'b0;
               end
            end
         end
         ST_POWER:
         begin
            // let the supply and mux settle before the first trial
            if (pwr_cnt == PWR_CYCLES[11:0] - 12'h001)
               state <= ST_START;
            else
               pwr_cnt <= pwr_cnt + 12'h001;
         end
         ST_START:
         begin
            sar_start <= 1'b1;
            state <= ST_WAIT;
         end
         ST_WAIT:
         begin
            if (sar_done)
            begin
               acc <= acc + {5'h00, fresh};
               if (fresh_under)
                  under <= 1'b1;
               if (fresh_over)
                  over <= 1'b1;
               if (pair_open)
               begin
                  comparator_swap <= 1'b1;
                  state <= ST_START;
               end
               else
               begin
                  comparator_swap <= 1'b0;
                  conv_left <= conv_left - 5'd1;
                  state <= (conv_left == 5'd1) ? ST_FINISH : ST_START;
               end
            end
         end
         ST_FINISH:
            state <= ST_IDLE;
         default:
            state <= ST_IDLE;
      endcase
   end
end

// results and status flags, once the supply is already off
always @(posedge clock or negedge rstn)
begin
   if (!rstn)
   begin
      main_working_register <= `RASQ_WORK_RESET;
      zero_flag <= 1'b0;
      negative_flag <= 1'b0;
      positive_flag <= 1'b0;
   end
   else if (state == ST_FINISH)
   begin
      if (op == `RASQ_CMD_CHECK)
      begin
         positive_flag <= (meas_word > main_working_register);
         negative_flag <= (meas_word < main_working_register);
         zero_flag <= (meas_word == main_working_register);
      end
      else
      begin
         main_working_register <= meas_word;
         negative_flag <= out_range;
         zero_flag <= under & ~over;
         positive_flag <= ~out_range;
      end
   end
   else if (wr_work & idle)
      main_working_register <= hwdata;
end

endmodule // rasq_sequencer

`default_nettype wire

//--- test/rasq_sensor_model.sv
`timescale 1ns/1ns
`default_nettype none
module rasq_sensor_model
(
   input wire logic clock, // system clock
   input wire logic [59:0] levels, // inputs 1..4 then reference
   input wire logic [11:0] dac_code, // trial code
   input wire logic swap, // comparator reversed
   input wire logic supply, // sensor supply
   input wire logic csrc, // current source on
   input wire logic ref_sel, // reference to converter
   input wire logic sel_lo, // mux select low
   input wire logic sel_hi, // mux select high
   output logic cmp // comparator out
);
   logic [2:0] idx;
   logic [11:0] vin;
   logic idle_q = 1'b0;
   assign idx = ref_sel ? 3'h4 : {1'b0, sel_hi, ~sel_lo};
   // input 4 is resistive: no voltage unless current flows
   assign vin = (idx == 3'h3 && !csrc) ? 12'h000 : levels[12*idx +: 12];
   always @(posedge clock)
      idle_q <= ~idle_q;
   // unpowered comparator toggles so a stale read never looks valid
   assign cmp = supply ? ((vin >= dac_code) ^ swap) : idle_q;
endmodule // rasq_sensor_model
`default_nettype wire

//--- test/rasq_sequencer_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module rasq_checker
#(
   parameter PWR_CYCLES = 100,
   parameter BIT_CYCLES = 8
)
(
   input wire clock, // system clock
   input wire rstn, // reset, active low
   input wire [11:0] dac_code, // trial code
   input wire comparator_swap, // reversed comparator
   input wire switched_sensor_supply, // sensor supply
   input wire current_source_en, // current source
   input wire reference_select_latch, // reference select
   input wire channel_select_lo, // mux low
   input wire channel_select_hi, // mux high
   input wire irq // interrupt
);
   wire sup = switched_sensor_supply;
   wire [2:0] sel = {reference_select_latch, channel_select_hi, channel_select_lo};
   logic [9:0] on_cnt;
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   // saturates so a stuck supply still reads as long
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         on_cnt <= 10'h000;
      else if (!sup)
         on_cnt <= 10'h000;
      else if (on_cnt != 10'h3ff)
         on_cnt <= on_cnt + 10'h001;
   end
   sequence s_start; dac_code != 12'h000 && $past(dac_code) == 12'h000; endsequence
   property p_csrc; !sup ##1 !sup |-> !current_source_en; endproperty
   a_csrc: assert property (p_csrc) else $error("source on, supply off");
   property p_dac_idle; !sup ##1 !sup |-> dac_code == 12'h000; endproperty
   a_dac_idle: assert property (p_dac_idle) else $error("conversion unpowered");
   property p_swap; comparator_swap |-> sup; endproperty
   a_swap: assert property (p_swap) else $error("swap outside conversion");
   property p_sel_hold; sup && $past(sup) |-> $stable(sel); endproperty
   a_sel_hold: assert property (p_sel_hold) else $error("select moved");
   property p_settle; s_start |-> on_cnt >= PWR_CYCLES - 1; endproperty
   a_settle: assert property (p_settle) else $error("conversion too early");
   property p_msb; s_start |-> dac_code == 12'h800; endproperty
   a_msb: assert property (p_msb) else $error("bad first trial");
   property p_sup_off; $rose(sup) |-> ##[1:1000] !sup; endproperty
   a_sup_off: assert property (p_sup_off) else $error("supply stuck on");
   property p_done_late; $rose(irq) |-> !sup; endproperty
   a_done_late: assert property (p_done_late) else $error("irq before supply off");
   property p_ref; $rose(reference_select_latch) |-> sup; endproperty
   a_ref: assert property (p_ref) else $error("reference without supply");
   c_comp: cover property ($rose(comparator_swap));
   c_batt: cover property ($rose(reference_select_latch));
   c_irq: cover property ($rose(irq));
endmodule // rasq_checker
bind rasq_sequencer rasq_checker #(.PWR_CYCLES(PWR_CYCLES), .BIT_CYCLES(BIT_CYCLES))
   rasq_checker_inst (.clock, .rstn, .dac_code, .comparator_swap, .switched_sensor_supply,
   .current_source_en, .reference_select_latch, .channel_select_lo, .channel_select_hi, .irq);
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "rasq_regs.vh"
`define CHK(got, exp) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) \
      begin \
         error_cnt++; \
         $display("MISMATCH %0t got %0h exp %0h", $time, got, exp); \
      end \
   end
module tb;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic lat = 1'b0;
   logic swap_seen = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] rd, hrdata;
   logic [11:0] dac_code;
   logic [11:0] dac_q = 12'h000;
   logic [59:0] levels = {12'h456, 12'hffe, 12'h001, 12'h000, 12'h123};
   logic hreadyout, hresp, cmp_pin, comparator_swap, irq, current_source_en;
   logic switched_sensor_supply, reference_select_latch, channel_select_lo, channel_select_hi;
   wire [4:0] outs = {switched_sensor_supply, channel_select_lo, channel_select_hi,
      reference_select_latch, current_source_en};
   int error_cnt = 0;
   int num_checks = 0;
   int conv_cnt = 0;
   // three settle cycles: the two-flop comparator sync must see each new trial code
   rasq_sequencer #(.PWR_CYCLES(2), .BIT_CYCLES(3)) rasq_sequencer_inst (.clock, .rstn,
      .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
      .hreadyout, .hresp, .cmp_pin, .dac_code, .comparator_swap, .switched_sensor_supply,
      .current_source_en, .reference_select_latch, .channel_select_lo, .channel_select_hi, .irq);
   rasq_sensor_model rasq_sensor_model_inst (.clock, .levels, .dac_code, .swap(comparator_swap),
      .supply(switched_sensor_supply), .csrc(current_source_en), .ref_sel(reference_select_latch),
      .sel_lo(channel_select_lo), .sel_hi(channel_select_hi), .cmp(cmp_pin));
   initial
   begin
      forever #25 clock = ~clock;
   end
   // each fresh 0x800 trial marks one conversion start
   always @(posedge clock)
   begin
      if (comparator_swap === 1'b1)
         swap_seen = 1'b1;
      if (dac_code === 12'h800 && dac_q !== 12'h800)
         conv_cnt++;
      dac_q = dac_code;
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic hang;
      error_cnt++;
      $display("MISMATCH %0t wait ran out", $time);
      final_report;
   endtask
   task automatic ready_edge;
      int n;
      n = 0;
      @(posedge clock);
      while (hreadyout !== 1'b1)
      begin
         n++;
         if (n > 20)
            hang;
         @(posedge clock);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      ready_edge;
      htrans <= 2'h0;
      hwdata <= d;
      ready_edge;
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rdk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      `CHK(rd, exp)
   endtask
   task automatic finish_op(input logic [31:0] exp, input logic [2:0] fl);
      int n;
      n = 0;
      bus(1'b0, `RASQ_FLAGS_OFS, 32'h0);
      while (rd[`RASQ_FLAG_BUSY_BIT] !== 1'b0)
      begin
         n++;
         if (n > 1000)
            hang;
         bus(1'b0, `RASQ_FLAGS_OFS, 32'h0);
      end
      `CHK(switched_sensor_supply, 1'b0)
      `CHK(rd[2:0], fl)
      rdk(`RASQ_WORK_OFS, exp);
   endtask
   task automatic measure(input logic [1:0] ch, input logic [7:0] spec, input logic [31:0] exp,
      input logic [2:0] fl);
      int nexp;
      nexp = (spec[3:0] == 4'h0 ? 16 : spec[3:0]) << spec[7];
      conv_cnt = 0;
      swap_seen = 1'b0;
      wr(`RASQ_CMD_OFS, {26'h0, ch, 2'h0, `RASQ_CMD_MEASURE});
      wr(`RASQ_SPEC_OFS, {24'h0, spec});
      @(posedge clock);
      `CHK(outs, {1'b1, ~ch[0], ch[1], 1'b0, lat})
      finish_op(exp, fl);
      `CHK(conv_cnt, nexp)
      `CHK(swap_seen, spec[7])
   endtask
   task automatic batt(input logic [1:0] code, input logic [31:0] exp, input logic [2:0] fl);
      wr(`RASQ_CMD_OFS, {30'h0, code});
      @(posedge clock);
      `CHK({outs[4], outs[1]}, 2'h3)
      finish_op(exp, fl);
   endtask
   task automatic irqk(input logic exp);
      repeat (2) @(posedge clock);
      `CHK(irq, exp)
   endtask
   task automatic t_reset;
      `CHK({irq, switched_sensor_supply, hresp}, 3'h0)
      rdk(`RASQ_WORK_OFS, `RASQ_WORK_RESET);
      rdk(`RASQ_IRQ_MASK_OFS, 32'h0);
      rdk(8'h40, 32'h0);
      wr(`RASQ_WORK_OFS, 32'ha5a5_0001);
      rdk(`RASQ_WORK_OFS, 32'ha5a5_0001);
      $display("test reset done");
   endtask
   task automatic t_measure;
      measure(2'h0, 8'h01, 32'h123, 3'h4);
      measure(2'h0, 8'h83, 32'h6d2, 3'h4);
      measure(2'h0, 8'h00, 32'h1230, 3'h4);
      measure(2'h2, 8'h01, 32'h1, 3'h4);
      measure(2'h1, 8'h01, 32'h0, 3'h3);
      lat = 1'b1;
      wr(`RASQ_LATCH_OFS, 32'h1);
      measure(2'h3, 8'h02, 32'h1ffc, 3'h4);
      lat = 1'b0;
      wr(`RASQ_LATCH_OFS, 32'h0);
      measure(2'h3, 8'h01, 32'h0, 3'h3);
      levels[35:24] <= 12'hfff;
      measure(2'h2, 8'h82, 32'hfff, 3'h2);
      $display("test measure done");
   endtask
   task automatic t_battery;
      logic [2:0] fl [3] = '{3'h4, 3'h1, 3'h2};
      batt(`RASQ_CMD_CALIBRATE, 32'h456, 3'h4);
      for (int i = 0; i < 3; i++)
      begin
         wr(`RASQ_WORK_OFS, 32'h455 + i);
         batt(`RASQ_CMD_CHECK, 32'h455 + i, fl[i]);
      end
      $display("test battery done");
   endtask
   task automatic t_irq;
      wr(`RASQ_IRQ_STAT_OFS, 32'h3);
      rdk(`RASQ_IRQ_STAT_OFS, 32'h0);
      measure(2'h1, 8'h01, 32'h0, 3'h3);
      irqk(1'b0);
      rdk(`RASQ_IRQ_STAT_OFS, 32'h3);
      wr(`RASQ_IRQ_MASK_OFS, 32'h1);
      irqk(1'b1);
      wr(`RASQ_IRQ_STAT_OFS, 32'h1);
      irqk(1'b0);
      wr(`RASQ_IRQ_MASK_OFS, 32'h3);
      irqk(1'b1);
      wr(`RASQ_IRQ_STAT_OFS, 32'h2);
      irqk(1'b0);
      $display("test irq done");
   endtask
   task automatic t_refuse;
      wr(`RASQ_SPEC_OFS, 32'h01);
      @(posedge clock);
      `CHK(switched_sensor_supply, 1'b0)
      rdk(`RASQ_FLAGS_OFS, 32'h3);
      $display("test refuse done");
   endtask
   initial
   begin
      repeat (6) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      t_reset;
      t_measure;
      t_battery;
      t_irq;
      t_refuse;
      final_report;
   end
endmodule // tb
`default_nettype wire
